// *** hdl/bfp_core.v ***
/*
 breaker failure protection core: pickup by mode, blocking, retrip and
 failure timers, on/off event strobes and a twelve-entry fault log.
 assumes currents, settings and inputs are synchronous to clock, and that
 an event consumer takes event_valid_q as a one-cycle strobe.
*/
`timescale 1ns/100ps
`include "bfp_defs.vh"
module bfp_core #(
    parameter STEP_CYCLES = `BFP_STEP_US * `BFP_CLK_MHZ
)
(
    input wire clock,
    input wire reset,
    input wire [`BFP_MODE_W-1:0] mode,
    input wire retrip_enable,
    input wire [`BFP_DLY_W-1:0] second_coil_delay_setting,
    input wire [`BFP_DLY_W-1:0] failure_delay_setting,
    input wire [`BFP_CUR_W-1:0] phase_a_current,
    input wire [`BFP_CUR_W-1:0] phase_b_current,
    input wire [`BFP_CUR_W-1:0] phase_c_current,
    input wire [`BFP_CUR_W-1:0] residual_input_one,
    input wire [`BFP_CUR_W-1:0] residual_input_two,
    input wire [`BFP_CUR_W-1:0] residual_calc,
    input wire [1:0] residual_select,
    input wire [`BFP_CUR_W-1:0] phase_pickup_threshold,
    input wire [`BFP_CUR_W-1:0] residual_pickup_threshold,
    input wire trip_output_monitor,
    input wire digital_signal,
    input wire block_in,
    input wire [1:0] event_store_select,
    input wire [`BFP_TIME_W-1:0] time_stamp,
    input wire [`BFP_SG_W-1:0] setting_group_index,
    input wire [`BFP_LOG_AW-1:0] log_read_index,
    output reg start_q,
    output reg blocked_q,
    output reg retrip_output_q,
    output reg breaker_failure_output_q,
    output reg [1:0] condition_q,
    output reg event_valid_q,
    output reg [`BFP_EVT_W-1:0] failure_event_block_q,
    output reg [`BFP_TIME_W-1:0] event_time_q,
    output reg [`BFP_CUR_W-1:0] event_phase_q,
    output reg [`BFP_CUR_W-1:0] event_residual_q,
    output reg [`BFP_LOG_AW-1:0] log_count_q,
    output reg [`BFP_REC_W-1:0] log_read_data_q
)
;
    // state of the operation, one-hot
    localparam ST_IDLE = 4'h1;
    localparam ST_START = 4'h2;
    localparam ST_BLOCK = 4'h4;
    localparam ST_OPER = 4'h8;

    // largest of three values, used for the phase maximum
    function [`BFP_CUR_W-1:0] max3;
        input [`BFP_CUR_W-1:0] a;
        input [`BFP_CUR_W-1:0] b;
        input [`BFP_CUR_W-1:0] c;
        reg [`BFP_CUR_W-1:0] m;
        begin
            m = (a > b) ? a : b;
            max3 = (m > c) ? m : c;
        end
    endfunction

    // pickup from mode: all three conditions given, combined per mode
    function pick;
        input [`BFP_MODE_W-1:0] md;
        input cur;
        input dout;
        input sig;
        begin
            case (md)
                `BFP_MODE_CUR: pick = cur;
                `BFP_MODE_DO: pick = dout;
                `BFP_MODE_SIG: pick = sig;
                `BFP_MODE_CUR_AND_DO: pick = cur && dout;
                `BFP_MODE_CUR_OR_DO: pick = cur || dout;
                `BFP_MODE_CUR_AND_SIG: pick = cur && sig;
                `BFP_MODE_CUR_OR_SIG_DO: pick = cur || sig || dout;
                `BFP_MODE_SIG_OR_DO: pick = sig || dout;
                `BFP_MODE_ANY: pick = cur || dout || sig;
                `BFP_MODE_ALL: pick = cur && dout && sig;
                default: pick = 1'b0;
            endcase
        end
    endfunction

    wire tick; // delay step pulse
    wire retrip_exp; // retrip timer done
    wire fail_exp; // failure timer done
    wire [`BFP_DLY_W-1:0] retrip_remain; // steps left to retrip
    wire [`BFP_DLY_W-1:0] fail_remain; // steps left to failure
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [`BFP_NEV-1:0] ev_prev_q; // last seen level of each event source
    reg [`BFP_LOG_AW-1:0] log_wr_q; // next log slot
    reg [`BFP_REC_W-1:0] log_mem [0:`BFP_LOG_DEPTH-1]; // fault records
    reg [`BFP_CUR_W-1:0] resid; // selected residual
    reg [`BFP_CUR_W-1:0] phase_max; // highest phase current
    reg phase_pu; // phase over threshold
    reg res_pu; // residual over threshold
    reg pickup; // combined pickup
    reg run_d; // timers may count
    reg [`BFP_NEV-1:0] ev_now; // current level of each event source
    reg [`BFP_NEV-1:0] ev_rise; // sources turning on
    reg [`BFP_NEV-1:0] ev_fall; // sources turning off
    reg ev_store; // an edge chosen for storage
    integer i;

    // residual source and comparators, all combinational so binary pickup has no delay
    always @*
    begin
        case (residual_select)
            2'h1: resid = residual_input_one;
            2'h2: resid = residual_input_two;
            2'h3: resid = residual_calc;
            default: resid = {`BFP_CUR_W{1'b0}};
        endcase
        phase_max = max3(phase_a_current, phase_b_current, phase_c_current);
        phase_pu = phase_max > phase_pickup_threshold;
        // residual unused when no source is chosen
        res_pu = (residual_select != 2'h0) && (resid > residual_pickup_threshold);
        // current-only, and/or of output and signal; binary signals act at once
        pickup = pick(mode, phase_pu || res_pu, trip_output_monitor, digital_signal);
    end

    // state machine for start, blocked and operate
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (pickup && block_in)
                    state_d = ST_BLOCK;
                else if (pickup)
                    state_d = ST_START;
            end
            ST_START:
            begin
                if (!pickup || block_in)
                    state_d = ST_IDLE;
                else if (fail_exp)
                    state_d = ST_OPER;
            end
            ST_BLOCK:
            begin
                // stays blocked while pickup and block_in both stand, no processing
                if (!pickup || !block_in)
                    state_d = ST_IDLE;
            end
            ST_OPER:
            begin
                if (!pickup || block_in)
                    state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
        // in and-modes the timers halt when pickup is lost is not allowed: pickup
        // itself is the and, so timer runs only while both hold
        run_d = (state_q == ST_START) || (state_q == ST_OPER);
    end

    bfp_step_tick #(
        .STEP_CYCLES(STEP_CYCLES)
    )
    u_tick (
        .clock(clock),
        .reset(reset),
        .tick_q(tick)
    );

    // retrip timer; held cleared when retrip is disabled
    bfp_delay_timer u_retrip (
        .clock(clock),
        .reset(reset),
        .run(run_d && pickup),
        .clear(!run_d || !pickup || !retrip_enable),
        .tick(tick),
        .delay_steps(second_coil_delay_setting),
        .expired_q(retrip_exp),
        .remain_q(retrip_remain)
    );

    // failure timer
    bfp_delay_timer u_fail (
        .clock(clock),
        .reset(reset),
        .run(run_d && pickup),
        .clear(!run_d || !pickup),
        .tick(tick),
        .delay_steps(failure_delay_setting),
        .expired_q(fail_exp),
        .remain_q(fail_remain)
    );

    // event levels and their edges
    always @*
    begin
        ev_now = {`BFP_NEV{1'b0}};
        ev_now[`BFP_EV_START] = (state_q == ST_START) || (state_q == ST_OPER);
        ev_now[`BFP_EV_RETRIP] = retrip_output_q;
        ev_now[`BFP_EV_FAIL] = breaker_failure_output_q;
        ev_now[`BFP_EV_BLOCK] = blocked_q;
        ev_now[`BFP_EV_DOMON] = trip_output_monitor;
        ev_now[`BFP_EV_SIGNAL] = digital_signal;
        ev_now[`BFP_EV_PHASE] = phase_pu;
        ev_now[`BFP_EV_RES] = res_pu;
        ev_rise = ev_now & ~ev_prev_q;
        ev_fall = ~ev_now & ev_prev_q;
        // user picks which edges are stored
        ev_store = ((event_store_select & `BFP_EVSEL_ON) != 2'h0 && ev_rise != {`BFP_NEV{1'b0}}) ||
                   ((event_store_select & `BFP_EVSEL_OFF) != 2'h0 && ev_fall != {`BFP_NEV{1'b0}});
    end

    // registered outputs, events and the fault log
    always @(posedge clock)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            start_q <= 1'b0;
            blocked_q <= 1'b0;
            retrip_output_q <= 1'b0;
            breaker_failure_output_q <= 1'b0;
            condition_q <= 2'h0;
            ev_prev_q <= {`BFP_NEV{1'b0}};
            event_valid_q <= 1'b0;
            failure_event_block_q <= {`BFP_EVT_W{1'b0}};
            event_time_q <= {`BFP_TIME_W{1'b0}};
            event_phase_q <= {`BFP_CUR_W{1'b0}};
            event_residual_q <= {`BFP_CUR_W{1'b0}};
            log_wr_q <= {`BFP_LOG_AW{1'b0}};
            log_count_q <= {`BFP_LOG_AW{1'b0}};
            log_read_data_q <= {`BFP_REC_W{1'b0}};
        end
        else
        begin
            state_q <= state_d;
            start_q <= (state_d == ST_START) || (state_d == ST_OPER);
            blocked_q <= state_d == ST_BLOCK;
            // retrip only when enabled, dropped with the timer
            retrip_output_q <= retrip_enable && retrip_exp && run_d && pickup;
            breaker_failure_output_q <= fail_exp && run_d && pickup;
            condition_q <= (state_d == ST_BLOCK) ? 2'h3 : (state_d == ST_OPER) ? 2'h2 :
                           (state_d == ST_START) ? 2'h1 : 2'h0;
            ev_prev_q <= ev_now;
            // event strobe: low half on edges, high half off edges
            event_valid_q <= ev_store;
            // only the kinds of edge chosen for storage are reported with the strobe
            failure_event_block_q <= {ev_fall & {`BFP_NEV{event_store_select[1]}},
                                      ev_rise & {`BFP_NEV{event_store_select[0]}}};
            event_time_q <= time_stamp;
            event_phase_q <= phase_max;
            event_residual_q <= resid;
            // new record on start, blocked or failure on-events, ring of twelve
            if (ev_rise[`BFP_EV_START] || ev_rise[`BFP_EV_BLOCK] || ev_rise[`BFP_EV_FAIL])
            begin
                log_wr_q <= (log_wr_q == `BFP_LOG_LAST) ? {`BFP_LOG_AW{1'b0}} : log_wr_q + 1'b1;
                if (log_count_q != `BFP_LOG_LAST + 1'b1)
                    log_count_q <= log_count_q + 1'b1;
            end
            if (log_read_index <= `BFP_LOG_LAST)
                log_read_data_q <= log_mem[log_read_index];
            else
                log_read_data_q <= {`BFP_REC_W{1'b0}};
        end
    end

    // log memory written apart from reset so it maps to plain storage
    always @(posedge clock)
    begin
        if (!reset && (ev_rise[`BFP_EV_START] || ev_rise[`BFP_EV_BLOCK] || ev_rise[`BFP_EV_FAIL]))
        begin
            for (i = 0; i < `BFP_LOG_DEPTH; i = i + 1)
            begin
                if (log_wr_q == i[`BFP_LOG_AW-1:0])
                    log_mem[i] <= {time_stamp, ev_rise, phase_max, resid, retrip_remain,
                                   fail_remain, setting_group_index};
            end
        end
    end
endmodule

// *** hdl/bfp_defs.vh ***
/*
 header of constants for the breaker failure protection block.
 assumes it is included by bare name from every design file.
*/
// Behaviour
// - current-only mode: overcurrent starts both timers
// - current-only: failure output after full delay
// - current-only: timers clear when currents drop
// - current-and-output: timers halt until trip active
// - current-and-output: run only while both true
// - current-and-output: reset when either condition drops
// - current-or-output: either condition starts timers
// - current-or-output: pickup held unless both inactive
// - current-or-output: retrip after retrip delay
// - current-or-output: reset only when both inactive
// - retrip unused: only failure timer and output
// - digital-input mode: input drives failure timer
// - separate on and off events per signal
// - user selects on, off or both events
// - events carry time stamp and process data
// - fault log keeps last twelve operations
// - record holds time, event, currents, times, group
// - blocked pickup gives blocked, not start
// - binary pickup acts with no delay
// - delays in 5 ms steps, defaults 100/200
// - retrip disabled suppresses retrip output
`ifndef BFP_DEFS_VH
`define BFP_DEFS_VH
`define BFP_CUR_W 16
`define BFP_TIME_W 32
`define BFP_DLY_W 19
`define BFP_EVT_W 16
`define BFP_SG_W 3
`define BFP_MODE_W 4
// operating modes
`define BFP_MODE_CUR 4'h0
`define BFP_MODE_DO 4'h1
`define BFP_MODE_SIG 4'h2
`define BFP_MODE_CUR_AND_DO 4'h3
`define BFP_MODE_CUR_OR_DO 4'h4
`define BFP_MODE_CUR_AND_SIG 4'h5
`define BFP_MODE_CUR_OR_SIG_DO 4'h6
`define BFP_MODE_SIG_OR_DO 4'h8
`define BFP_MODE_ANY 4'h9
`define BFP_MODE_ALL 4'hA
// event storage select
`define BFP_EVSEL_ON 2'h1
`define BFP_EVSEL_OFF 2'h2
// delay step in microseconds, defaults in steps, and the clock rate
`define BFP_STEP_US 5000
`define BFP_CLK_MHZ 250
`define BFP_RETRIP_DEF_STEPS 19'h00014
`define BFP_FAIL_DEF_STEPS 19'h00028
// event bit positions
`define BFP_EV_START 0
`define BFP_EV_RETRIP 1
`define BFP_EV_FAIL 2
`define BFP_EV_BLOCK 3
`define BFP_EV_DOMON 4
`define BFP_EV_SIGNAL 5
`define BFP_EV_PHASE 6
`define BFP_EV_RES 7
`define BFP_NEV 8
`define BFP_LOG_DEPTH 12
`define BFP_LOG_AW 4
`define BFP_LOG_LAST 4'hB
`define BFP_REC_W 133
`endif

// *** hdl/bfp_step_tick.v ***
/*
 divider that makes one-cycle pulses at the delay step rate.
 assumes a free-running clock at the rate in the header.
*/
`timescale 1ns/100ps
`include "bfp_defs.vh"
module bfp_step_tick #(
    parameter STEP_CYCLES = `BFP_STEP_US * `BFP_CLK_MHZ
)
(
    input wire clock,
    input wire reset,
    output reg tick_q
);
    reg [20:0] cnt_q; // cycles within the step
    // count up, pulse on wrap; 5 ms step times 250 MHz needs 21 bits
    always @(posedge clock)
    begin
        if (reset)
        begin
            cnt_q <= 21'h000000;
            tick_q <= 1'b0;
        end
        else if (cnt_q == STEP_CYCLES[20:0] - 21'h000001)
        begin
            cnt_q <= 21'h000000;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 21'h000001;
            tick_q <= 1'b0;
        end
    end
endmodule

// *** hdl/bfp_delay_timer.v ***
/*
 one delay timer counting step pulses while running.
 assumes the step pulse is one cycle wide.
*/
`timescale 1ns/100ps
`include "bfp_defs.vh"
module bfp_delay_timer (
    input wire clock,
    input wire reset,
    input wire run,
    input wire clear,
    input wire tick,
    input wire [`BFP_DLY_W-1:0] delay_steps,
    output reg expired_q,
    output reg [`BFP_DLY_W-1:0] remain_q
)
;
    reg [`BFP_DLY_W-1:0] elapsed_q; // steps counted so far
    // clear wins over run; halted when run is low but not cleared
    always @(posedge clock)
    begin
        if (reset || clear)
        begin
            elapsed_q <= {`BFP_DLY_W{1'b0}};
            expired_q <= 1'b0;
            remain_q <= delay_steps;
        end
        else
        begin
            if (run && tick && !expired_q)
            begin
                elapsed_q <= elapsed_q + 1'b1;
            end
            expired_q <= expired_q || (run && elapsed_q >= delay_steps);
            remain_q <= (elapsed_q >= delay_steps) ? {`BFP_DLY_W{1'b0}} : delay_steps - elapsed_q;
        end
    end
endmodule

// *** verif/bfp_core_assertions.sv ***
/* assertions on the breaker failure core ports.
 assumes one clock, sync reset and delay settings held steady. */
`timescale 1ns/100ps
`include "bfp_defs.vh"
module bfp_core_assertions #(
    parameter STEP_CYCLES = 10
)
(
    input wire clock,
    input wire reset,
    input wire [`BFP_MODE_W-1:0] mode,
    input wire retrip_enable,
    input wire [`BFP_DLY_W-1:0] failure_delay_setting,
    input wire [`BFP_CUR_W-1:0] phase_a_current,
    input wire [`BFP_CUR_W-1:0] phase_b_current,
    input wire [`BFP_CUR_W-1:0] phase_c_current,
    input wire [1:0] residual_select,
    input wire [`BFP_CUR_W-1:0] phase_pickup_threshold,
    input wire trip_output_monitor,
    input wire digital_signal,
    input wire block_in,
    input wire [1:0] event_store_select,
    input wire start_q,
    input wire blocked_q,
    input wire retrip_output_q,
    input wire breaker_failure_output_q,
    input wire event_valid_q,
    input wire [`BFP_EVT_W-1:0] failure_event_block_q,
    input wire [`BFP_LOG_AW-1:0] log_count_q
);
    // phase pickup only; residual pickup is left out, so users gate on select 0
    wire thr_lo = phase_a_current <= phase_pickup_threshold && phase_b_current <= phase_pickup_threshold;
    wire ph_low = thr_lo && phase_c_current <= phase_pickup_threshold && residual_select == 2'h0;
    reg [31:0] run_q; // cycles start has stood
    wire [31:0] run_d = start_q ? run_q + 32'h1 : 32'h0;
    // time in start bounds how early the failure output may rise
    always @(posedge clock)
    begin
        run_q <= reset ? 32'h0 : run_d;
    end
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    a_block_no_start: assert property (blocked_q |-> !start_q)
        else $error("start shown while blocked");
    a_retrip_off: assert property ((!retrip_enable)[*3] |-> !retrip_output_q)
        else $error("retrip output while disabled");
    a_cur_drop: assert property ((mode == `BFP_MODE_CUR && ph_low)[*3] |-> !breaker_failure_output_q && !start_q)
        else $error("outputs stand without current");
    a_and_halt: assert property ((mode == `BFP_MODE_CUR_AND_DO && !trip_output_monitor)[*3]
        |-> !retrip_output_q && !breaker_failure_output_q)
        else $error("timer ran without trip monitor");
    a_or_drop: assert property ((mode == `BFP_MODE_CUR_OR_DO && ph_low && !trip_output_monitor)[*3]
        |-> !start_q && !retrip_output_q)
        else $error("pickup stands with both causes gone");
    a_fail_min_time: assert property ($rose(breaker_failure_output_q) && failure_delay_setting != 0
        |-> run_q >= (failure_delay_setting - 1) * STEP_CYCLES)
        else $error("failure output before its delay");
    a_event_bits: assert property (event_valid_q |-> failure_event_block_q != 16'h0000)
        else $error("event strobe with no event bit");
    a_on_only: assert property (event_valid_q && event_store_select == `BFP_EVSEL_ON
        |-> failure_event_block_q[15:8] == 8'h00)
        else $error("off event stored while only on selected");
    a_log_bound: assert property (log_count_q <= `BFP_LOG_DEPTH)
        else $error("log count above depth");
    a_signal_fast: assert property (mode == `BFP_MODE_SIG && $rose(digital_signal) && !block_in && !blocked_q
        |-> ##[1:2] start_q)
        else $error("signal pickup delayed");
endmodule
bind bfp_core bfp_core_assertions #(.STEP_CYCLES(STEP_CYCLES)) u_bfp_chk (.*);

// *** verif/bfp_breaker_model.sv ***
/* feeder breaker with a redundant coil, and the incomer breaker.
 assumes coils come from the core outputs and reclose from the bench. */
`timescale 1ns/100ps
module bfp_breaker_model #(
    parameter OPEN_CYCLES = 8'h05
)
(
    input wire clock,
    input wire retrip_coil,
    input wire incomer_coil,
    input wire healthy,
    input wire reclose,
    output reg feeder_closed_q,
    output reg incomer_closed_q
);
    reg [7:0] feed_t_q; // cycles the redundant coil is fed
    reg [7:0] inc_t_q; // cycles the incomer coil is fed
    // a stuck feeder ignores its coil, which is why the failure timer exists
    always @(posedge clock)
    begin
        if (reclose)
        begin
            feed_t_q <= 8'h00;
            inc_t_q <= 8'h00;
            feeder_closed_q <= 1'b1;
            incomer_closed_q <= 1'b1;
        end
        else
        begin
            if (retrip_coil && healthy)
                feed_t_q <= feed_t_q + 8'h01;
            if (incomer_coil)
                inc_t_q <= inc_t_q + 8'h01;
            if (feed_t_q == OPEN_CYCLES)
                feeder_closed_q <= 1'b0;
            if (inc_t_q == OPEN_CYCLES)
                incomer_closed_q <= 1'b0;
        end
    end
endmodule

// *** verif/bfp_core_test.sv ***
/* self-checking bench for the breaker failure core and the breaker model.
 assumes a step of ten cycles so each delay lasts a few dozen cycles. */
`timescale 1ns/100ps
`include "bfp_defs.vh"
module bfp_core_test;
    localparam STEP = 10; // cycles per delay step
    localparam LIM = 5 * STEP + 8; // longest wait for an output
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [3:0] mode = 4'h0;
    logic ren = 1'b1; // retrip enable
    logic [15:0] ph = 16'h0000; // phase current at the source
    logic [15:0] rc = 16'h0000; // residual current at the source
    logic [1:0] psel = 2'h0; // faulted phase
    logic [1:0] rsel = 2'h0; // residual source
    logic dom = 1'b0; // primary trip output monitor
    logic dsig = 1'b0;
    logic blk = 1'b0;
    logic healthy = 1'b0; // feeder breaker obeys its redundant coil
    logic [1:0] evsel = 2'h3;
    logic [31:0] ts = 32'h0;
    logic [2:0] sg = 3'h0;
    logic [3:0] lidx = 4'h0;
    wire fc, ic, st, bl, rt, bf, evv;
    wire [1:0] cond;
    wire [15:0] evb, evph, evres;
    wire [31:0] evtm;
    wire [3:0] lcnt;
    wire [`BFP_REC_W-1:0] lrd;
    int n_errors = 0;
    int cmp_count = 0;
    int waited;
    // current flows only while both breakers are closed
    wire live = fc === 1'b1 && ic === 1'b1;
    always #2 clock = ~clock;
    always @(negedge clock) ts <= ts + 32'h1;
    bfp_breaker_model u_brk (.clock(clock), .retrip_coil(rt), .incomer_coil(bf), .healthy(healthy),
        .reclose(ph == 16'h0000 && rc == 16'h0000), .feeder_closed_q(fc), .incomer_closed_q(ic));
    bfp_core #(.STEP_CYCLES(STEP)) dut (.clock(clock), .reset(reset), .mode(mode), .retrip_enable(ren),
        .second_coil_delay_setting(19'h00002), .failure_delay_setting(19'h00004),
        .phase_a_current(live && psel == 2'h0 ? ph : 16'h0000),
        .phase_b_current(live && psel == 2'h1 ? ph : 16'h0000),
        .phase_c_current(live && psel == 2'h2 ? ph : 16'h0000),
        .residual_input_one(live && rsel == 2'h1 ? rc : 16'h0000),
        .residual_input_two(live && rsel == 2'h2 ? rc : 16'h0000),
        .residual_calc(live && rsel == 2'h3 ? rc : 16'h0000), .residual_select(rsel),
        .phase_pickup_threshold(16'h0100), .residual_pickup_threshold(16'h0080),
        .trip_output_monitor(dom), .digital_signal(dsig), .block_in(blk), .event_store_select(evsel),
        .time_stamp(ts), .setting_group_index(sg), .log_read_index(lidx), .start_q(st), .blocked_q(bl),
        .retrip_output_q(rt), .breaker_failure_output_q(bf), .condition_q(cond), .event_valid_q(evv),
        .failure_event_block_q(evb), .event_time_q(evtm), .event_phase_q(evph), .event_residual_q(evres),
        .log_count_q(lcnt), .log_read_data_q(lrd));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic pick(input int w);
        return w == 0 ? rt : w == 1 ? bf : w == 2 ? st : evv && evb[0];
    endfunction
    // poll at falling edges, bounded, so a dead output cannot hang the run
    task wait_sig(input int w, input int lim);
        waited = 0;
        while (waited < lim && pick(w) !== 1'b1)
        begin
            @(negedge clock);
            waited++;
        end
        chk(pick(w), 1'b1);
    endtask
    task drive(input logic [3:0] m, input logic [15:0] i, input logic d, input logic s);
        @(negedge clock);
        mode = m;
        ph = i;
        dom = d;
        dsig = s;
    endtask
    task settle;
        repeat (4) @(negedge clock);
    endtask
    task t_cur_only;
        drive(`BFP_MODE_CUR, 16'h0200, 1'b0, 1'b0);
        wait_sig(2, 4);
        wait_sig(3, 4);
        chk(evph, 16'h0200);
        chk(evres, 16'h0000);
        chk(evtm, ts);
        wait_sig(0, LIM);
        chk(bf, 1'b0);
        wait_sig(1, LIM);
        @(negedge clock);
        chk(cond, 2'h2);
        drive(`BFP_MODE_CUR, 16'h0000, 1'b0, 1'b0);
        settle;
        chk({st, rt, bf}, 3'h0);
        $display("done current only");
    endtask
    task t_and_mode;
        psel = 2'h2;
        drive(`BFP_MODE_CUR_AND_DO, 16'h0200, 1'b0, 1'b0);
        repeat (LIM) @(negedge clock);
        chk({rt, bf}, 2'h0);
        drive(`BFP_MODE_CUR_AND_DO, 16'h0200, 1'b1, 1'b0);
        wait_sig(0, LIM);
        drive(`BFP_MODE_CUR_AND_DO, 16'h0200, 1'b0, 1'b0);
        settle;
        chk({st, rt, bf}, 3'h0);
        drive(`BFP_MODE_CUR_AND_DO, 16'h0000, 1'b0, 1'b0);
        settle;
        $display("done current and monitor");
    endtask
    task t_or_mode;
        psel = 2'h1;
        drive(`BFP_MODE_CUR_OR_DO, 16'h0000, 1'b1, 1'b0);
        wait_sig(0, LIM);
        drive(`BFP_MODE_CUR_OR_DO, 16'h0200, 1'b1, 1'b0);
        drive(`BFP_MODE_CUR_OR_DO, 16'h0200, 1'b0, 1'b0);
        settle;
        chk({st, rt}, 2'h3);
        drive(`BFP_MODE_CUR_OR_DO, 16'h0000, 1'b0, 1'b0);
        settle;
        chk({st, rt, bf}, 3'h0);
        $display("done current or monitor");
    endtask
    task t_no_retrip;
        ren = 1'b0;
        drive(`BFP_MODE_CUR, 16'h0200, 1'b0, 1'b0);
        wait_sig(1, LIM);
        chk(rt, 1'b0);
        drive(`BFP_MODE_CUR, 16'h0000, 1'b0, 1'b0);
        settle;
        ren = 1'b1;
        $display("done retrip disabled");
    endtask
    task t_signal;
        drive(`BFP_MODE_SIG, 16'h0000, 1'b0, 1'b1);
        wait_sig(2, 3);
        wait_sig(1, LIM);
        drive(`BFP_MODE_SIG, 16'h0000, 1'b0, 1'b0);
        settle;
        chk({st, bf}, 2'h0);
        $display("done signal mode");
    endtask
    task t_block;
        blk = 1'b1;
        drive(`BFP_MODE_CUR, 16'h0200, 1'b0, 1'b0);
        settle;
        chk({bl, st, cond}, 4'hB);
        repeat (LIM) @(negedge clock);
        chk({rt, bf}, 2'h0);
        drive(`BFP_MODE_CUR, 16'h0000, 1'b0, 1'b0);
        blk = 1'b0;
        settle;
        $display("done blocked");
    endtask
    // a healthy feeder clears the fault on retrip, so the incomer is spared
    task t_redundant_coil;
        evsel = `BFP_EVSEL_ON;
        healthy = 1'b1;
        for (int i = 1; i < 4; i++)
        begin
            rsel = i[1:0];
            rc = 16'h0100;
            wait_sig(0, LIM);
            repeat (LIM) @(negedge clock);
            chk({st, bf}, 2'h0);
            rc = 16'h0000;
            settle;
        end
        healthy = 1'b0;
        evsel = 2'h3;
        $display("done redundant coil");
    endtask
    task t_fault_log;
        blk = 1'b1;
        sg = 3'h5;
        repeat (13)
        begin
            drive(`BFP_MODE_SIG, 16'h0000, 1'b0, 1'b1);
            settle;
            drive(`BFP_MODE_SIG, 16'h0000, 1'b0, 1'b0);
            settle;
        end
        chk(lcnt, 4'hC);
        for (int i = 0; i < 12; i++)
        begin
            lidx = i[3:0];
            repeat (2) @(negedge clock);
            chk(lrd[2:0], 3'h5);
        end
        blk = 1'b0;
        $display("done fault log");
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(negedge clock);
        reset = 1'b0;
        chk({st, bl, rt, bf, lcnt}, 8'h00);
        t_cur_only;
        t_and_mode;
        t_or_mode;
        t_no_retrip;
        t_signal;
        t_block;
        t_redundant_coil;
        t_fault_log;
        print_verdict;
    end
    // the whole run needs about 750 cycles
    initial
    begin
        repeat (4000) @(posedge clock);
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        print_verdict;
    end
endmodule
